// ===== hw/sbra_arbiter.sv
// Multi-master SPI bus release arbiter with slave interrupt monitor
//
// What this block does
// - Works alone or with other masters under arbitration
// - Select-role pins drive slave selects during transfers
// - Dedicated monitor pin samples slave interrupts
// - Dedicated request pin asks bridge to release bus
// - Dedicated grant pin acknowledges bus release
// - Pending release lets current transfer finish
// - Host cancel aborts transfer while release pending
// - Release bus and assert grant on the same edge
// - Other master owns bus while request held
module sbra_arbiter
#(
    parameter int SELECTS = sbra_pkg::SELECT_COUNT
)
(
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // Pin role configuration from the host side
    input  wire logic [SELECTS-1:0] selectRoleEn,
    input  wire logic [SELECTS-1:0] selectIdleLevel,
    input  wire logic [SELECTS-1:0] selectActiveLevel,
    input  wire logic               irqMonitorEn,
    input  wire logic               arbitrationEn,
    // Transfer engine side
    input  wire logic               xferStart,
    input  wire logic               xferDone,
    input  wire logic               xferCancel,
    output logic                    xferAccept,
    output logic                    xferAbort,
    output logic                    busOwned,
    output logic                    releasePending,
    // Serial engine outputs to be gated onto the bus
    input  wire logic               engSclk,
    input  wire logic               engMosi,
    // SPI bus pins (enable low while driving)
    output logic                    spiSclkOut,
    output logic                    spiSclkOe_n,
    output logic                    spiMosiOut,
    output logic                    spiMosiOe_n,
    output logic [SELECTS-1:0]      slave_select_lines,
    output logic [SELECTS-1:0]      slaveSelectOe_n,
    // Dedicated pins
    input  wire logic               slave_irq_monitor_pin,
    input  wire logic               bus_request_pin,
    output logic                    bus_grant_pin,
    output logic                    slaveIrqLevel
);

    // All state of the arbiter
    typedef struct packed {
        sbra_pkg::sbra_state_type state;
        logic [3:0]               reclaimCount;
        logic                     accept;
        logic                     abort;
        logic                     owned;
        logic                     pending;
        logic                     grant;
        logic                     irq;
        logic                     sclk;
        logic                     sclkOe_n;
        logic                     mosi;
        logic                     mosiOe_n;
        logic [SELECTS-1:0]       sel;
        logic [SELECTS-1:0]       selOe_n;
    } sbra_arb_type;

    sbra_arb_type arbReg;   // Registered state
    sbra_arb_type arbNext;  // Next state

    logic requestLevel;     // Filtered request pin
    logic irqPinLevel;      // Filtered interrupt pin
    logic requestActive;    // Request honoured only in dedicated role
    logic busDrive;         // Bus drivers enabled next cycle
    logic inXfer;           // Transfer active next cycle

    // Request pin synchroniser
    sbra_pin_sync requestSync
    (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .pinIn    (bus_request_pin),
        .pinLevel (requestLevel)
    );

    // Interrupt monitor pin synchroniser
    sbra_pin_sync irqSync
    (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .pinIn    (slave_irq_monitor_pin),
        .pinLevel (irqPinLevel)
    );

    // Next-state logic
    always_comb
    begin
        arbNext = arbReg;
        arbNext.accept = 1'b0;
        arbNext.abort = 1'b0;
        requestActive = arbitrationEn && requestLevel;
        // Monitor level reported only in dedicated role
        arbNext.irq = irqMonitorEn && irqPinLevel;
        unique case (arbReg.state)
            sbra_pkg::ST_IDLE:
            begin
                // Request wins over a new start, so the other master is not starved
                if (requestActive)
                begin
                    arbNext.state = sbra_pkg::ST_RELEASED;
                end
                else if (xferStart)
                begin
                    arbNext.state = sbra_pkg::ST_XFER;
                    arbNext.accept = 1'b1;
                end
            end
            sbra_pkg::ST_XFER:
            begin
                if (xferDone)
                begin
                    arbNext.state = requestActive ? sbra_pkg::ST_RELEASED
                                                  : sbra_pkg::ST_IDLE;
                end
                else if (requestActive)
                begin
                    arbNext.state = sbra_pkg::ST_DRAIN;
                end
            end
            sbra_pkg::ST_DRAIN:
            begin
                // Finish or host-cancel; request drop meanwhile returns to normal
                if (xferCancel)
                begin
                    arbNext.abort = 1'b1;
                    arbNext.state = requestActive ? sbra_pkg::ST_RELEASED
                                                  : sbra_pkg::ST_IDLE;
                end
                else if (xferDone)
                begin
                    arbNext.state = requestActive ? sbra_pkg::ST_RELEASED
                                                  : sbra_pkg::ST_IDLE;
                end
                else if (!requestActive)
                begin
                    arbNext.state = sbra_pkg::ST_XFER;
                end
            end
            sbra_pkg::ST_RELEASED:
            begin
                // Hold off while the other master keeps its request
                if (!requestActive)
                begin
                    arbNext.state = sbra_pkg::ST_RECLAIM;
                    arbNext.reclaimCount = sbra_pkg::RECLAIM_CYCLES;
                end
            end
            sbra_pkg::ST_RECLAIM:
            begin
                // Grant is already low; wait before driving again
                if (requestActive)
                begin
                    arbNext.state = sbra_pkg::ST_RELEASED;
                end
                else if (arbReg.reclaimCount == 4'h0)
                begin
                    arbNext.state = sbra_pkg::ST_IDLE;
                end
                else
                begin
                    arbNext.reclaimCount = arbReg.reclaimCount - 4'h1;
                end
            end
            default:
            begin
                arbNext.state = sbra_pkg::ST_IDLE;
            end
        endcase

        inXfer = (arbNext.state == sbra_pkg::ST_XFER)
              || (arbNext.state == sbra_pkg::ST_DRAIN);
        busDrive = (arbNext.state != sbra_pkg::ST_RELEASED)
                && (arbNext.state != sbra_pkg::ST_RECLAIM);
        // Grant only in released state; drivers off that same edge
        arbNext.grant = (arbNext.state == sbra_pkg::ST_RELEASED);
        arbNext.owned = busDrive;
        arbNext.pending = requestActive && busDrive;

        // Bus outputs; idle levels when owned but not transferring
        arbNext.sclk = inXfer ? engSclk : 1'b0;
        arbNext.mosi = inXfer ? engMosi : 1'b0;
        arbNext.sclkOe_n = !busDrive;
        arbNext.mosiOe_n = !busDrive;
        for (int i = 0; i < SELECTS; i++)
        begin
            // Select pins asserted only during a transfer
            arbNext.sel[i] = inXfer ? selectActiveLevel[i] : selectIdleLevel[i];
            arbNext.selOe_n[i] = !(busDrive && selectRoleEn[i]);
        end
    end

    // State register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arbReg <= '{state:        sbra_pkg::ST_IDLE,
                        reclaimCount: 4'h0,
                        accept:       1'b0,
                        abort:        1'b0,
                        owned:        1'b1,
                        pending:      1'b0,
                        grant:        sbra_pkg::GRANT_RESET,
                        irq:          1'b0,
                        sclk:         1'b0,
                        sclkOe_n:     1'b0,
                        mosi:         1'b0,
                        mosiOe_n:     1'b0,
                        sel:          SELECTS'(sbra_pkg::SELECT_IDLE_RESET),
                        selOe_n:      '1};
        end
        else
        begin
            arbReg <= arbNext;
        end
    end

    // Outputs straight from the state register
    assign xferAccept         = arbReg.accept;
    assign xferAbort          = arbReg.abort;
    assign busOwned           = arbReg.owned;
    assign releasePending     = arbReg.pending;
    assign spiSclkOut         = arbReg.sclk;
    assign spiSclkOe_n        = arbReg.sclkOe_n;
    assign spiMosiOut         = arbReg.mosi;
    assign spiMosiOe_n        = arbReg.mosiOe_n;
    assign slave_select_lines = arbReg.sel;
    assign slaveSelectOe_n    = arbReg.selOe_n;
    assign bus_grant_pin      = arbReg.grant;
    assign slaveIrqLevel      = arbReg.irq;

endmodule

// ===== common/sbra_pkg.sv
// Package: constants and types for the SPI bus release arbiter
package sbra_pkg;

    // Number of general-purpose pins that can act as slave selects
    localparam int SELECT_COUNT = 9;

    // Pin input synchroniser depth
    localparam int SYNC_DEPTH = 3;

    // Pin role codes, one per general-purpose pin
    typedef enum logic [1:0] {
        ROLE_GPIO      = 2'h0,
        ROLE_SELECT    = 2'h1,
        ROLE_DEDICATED = 2'h2
    } sbra_role_type;

    // Arbiter states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_XFER     = 3'h1,
        ST_DRAIN    = 3'h2,
        ST_RELEASED = 3'h3,
        ST_RECLAIM  = 3'h4
    } sbra_state_type;

    // Reset values
    localparam logic [8:0] SELECT_IDLE_RESET = 9'h1FF;
    localparam logic       GRANT_RESET       = 1'h0;

    // One less than the cycles spent between dropping grant and taking the bus back
    localparam logic [3:0] RECLAIM_CYCLES = 4'h2;

endpackage

// ===== hw/sbra_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin input
module sbra_pin_sync
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Raw pin and filtered level
    input  wire logic pinIn,
    output logic      pinLevel
);

    // All state of the synchroniser
    typedef struct packed {
        logic [2:0] stages;
        logic       level;
    } sbra_sync_type;

    sbra_sync_type syncReg;   // Registered state
    sbra_sync_type syncNext;  // Next state

    // Shift in; accept a change only once stages 2 and 3 agree.
    // Stage 1 is read only by stage 2, keeping metastability contained.
    always_comb
    begin
        syncNext = syncReg;
        syncNext.stages = {syncReg.stages[1:0], pinIn};
        if (syncReg.stages[2] == syncReg.stages[1])
        begin
            syncNext.level = syncReg.stages[2];
        end
    end

    // State register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncReg <= '0;
        end
        else
        begin
            syncReg <= syncNext;
        end
    end

    assign pinLevel = syncReg.level;

endmodule

// ===== testbench/sbra_arbiter_monitor.sv
// Concurrent checks on the bus release arbiter ports
module sbra_arbiter_monitor
#(
    parameter int SELECTS = 9
)
(
    // Clock and reset
    input wire logic               mclk,
    input wire logic               reset_n,
    // Transfer handshake
    input wire logic               xferStart,
    input wire logic               xferDone,
    input wire logic               xferCancel,
    input wire logic               xferAccept,
    input wire logic               xferAbort,
    input wire logic               busOwned,
    input wire logic               releasePending,
    // Bus enables and arbitration pins
    input wire logic               spiSclkOe_n,
    input wire logic               spiMosiOe_n,
    input wire logic [SELECTS-1:0] slaveSelectOe_n,
    input wire logic               bus_request_pin,
    input wire logic               bus_grant_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    // Transfer in flight; held from accept until done or abort
    logic inXfer_reg;

    // Tracks the engine's transfer window
    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n)
            inXfer_reg <= 1'b0;
        else
            inXfer_reg <= xferAccept ? 1'b1 : (xferDone || xferAbort) ? 1'b0 : inXfer_reg;

    property p_quiet;
        bus_grant_pin |-> spiSclkOe_n && spiMosiOe_n && (&slaveSelectOe_n);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("Bus driven while granted");

    property p_owner;
        bus_grant_pin |-> !busOwned;
    endproperty
    a_owner: assert property (p_owner)
        else $error("Grant while owning bus");

    property p_done_grant;
        releasePending && inXfer_reg && xferDone |=> bus_grant_pin;
    endproperty
    a_done_grant: assert property (p_done_grant)
        else $error("No grant after done");

    property p_cancel;
        releasePending && inXfer_reg && xferCancel |=> xferAbort && bus_grant_pin;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("Cancel did not abort");

    property p_abort_cause;
        xferAbort |-> $past(xferCancel) && $past(releasePending);
    endproperty
    a_abort_cause: assert property (p_abort_cause)
        else $error("Abort without cancel");

    property p_no_cut;
        inXfer_reg && !xferAbort |-> !bus_grant_pin;
    endproperty
    a_no_cut: assert property (p_no_cut)
        else $error("Bus released mid transfer");

    property p_hold;
        bus_request_pin [*5] ##0 bus_grant_pin |=> bus_grant_pin;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Grant dropped while requested");

    property p_no_start;
        xferStart && bus_grant_pin |=> !xferAccept;
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("Start taken while released");

    property p_reclaim;
        $fell(bus_grant_pin) |-> !busOwned ##[2:4] busOwned;
    endproperty
    a_reclaim: assert property (p_reclaim)
        else $error("Reclaim timing wrong");

    c_drain_done: cover property (releasePending && xferDone);
    c_abort: cover property (xferAbort);
    c_reclaim: cover property ($fell(bus_grant_pin));
endmodule

bind sbra_arbiter sbra_arbiter_monitor #(.SELECTS(SELECTS)) i_sbra_arbiter_monitor (
    .mclk, .reset_n, .xferStart, .xferDone, .xferCancel, .xferAccept, .xferAbort,
    .busOwned, .releasePending, .spiSclkOe_n, .spiMosiOe_n, .slaveSelectOe_n,
    .bus_request_pin, .bus_grant_pin
);

// ===== testbench/sbra_other_master.sv
// Model of the second master sharing the bus
module sbra_other_master
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Bench command and handshake pins
    input wire logic wantBus,
    input wire logic bus_grant_pin,
    output logic     bus_request_pin,
    // Own bus drive, high while driving
    output logic     otherSclk,
    output logic     otherOe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Request, wait for grant, drive; stop driving before dropping request
    always @(posedge mclk or negedge reset_n)
        if (!reset_n)
        begin
            bus_request_pin <= 1'b0;
            otherOe <= 1'b0;
            otherSclk <= 1'b0;
        end
        else
        begin
            bus_request_pin <= wantBus | otherOe;
            otherOe <= wantBus & bus_grant_pin & bus_request_pin;
            // Clock stands still as soon as the bench lets go of the bus
            otherSclk <= otherOe & wantBus & ~otherSclk;
        end
endmodule

// ===== testbench/tb.sv
// Testbench for the SPI bus release arbiter
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and counters
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    int         err_total = 0;
    int         comparisons = 0;
    // Stimulus
    logic [8:0] roleEn = 9'h0F5;
    logic [8:0] idleLvl = 9'h1FF;
    logic [8:0] actLvl = 9'h000;
    logic       irqEn = 1'b0, arbEn = 1'b1, irqPin = 1'b0, wantBus = 1'b0;
    logic       xferStart = 1'b0, xferDone = 1'b0, xferCancel = 1'b0, engMosi = 1'b0;
    logic       engSclk = 1'b0;
    // Observed outputs
    logic       accept, abort, busOwned, pending, sclkOut, sclkOe_n, mosiOut, mosiOe_n;
    logic       reqPin, grantPin, irqLevel, otherSclk, otherOe;
    logic [8:0] selLines, selOe_n;

    always #12.5 mclk = ~mclk;

    sbra_arbiter i_sbra_arbiter (.mclk(mclk), .reset_n(reset_n), .selectRoleEn(roleEn),
        .selectIdleLevel(idleLvl), .selectActiveLevel(actLvl), .irqMonitorEn(irqEn),
        .arbitrationEn(arbEn), .xferStart(xferStart), .xferDone(xferDone),
        .xferCancel(xferCancel), .xferAccept(accept), .xferAbort(abort),
        .busOwned(busOwned), .releasePending(pending), .engSclk(engSclk),
        .engMosi(engMosi), .spiSclkOut(sclkOut), .spiSclkOe_n(sclkOe_n),
        .spiMosiOut(mosiOut), .spiMosiOe_n(mosiOe_n), .slave_select_lines(selLines),
        .slaveSelectOe_n(selOe_n), .slave_irq_monitor_pin(irqPin),
        .bus_request_pin(reqPin), .bus_grant_pin(grantPin), .slaveIrqLevel(irqLevel));

    sbra_other_master i_sbra_other_master (.mclk(mclk), .reset_n(reset_n),
        .wantBus(wantBus), .bus_grant_pin(grantPin), .bus_request_pin(reqPin),
        .otherSclk(otherSclk), .otherOe(otherOe));

    // One comparison, counted
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Bounded wait on a design output
    task automatic waitOn(input string n, ref logic s, input logic v);
        for (int i = 0; i < 40 && s !== v; i++)
            @(posedge mclk);
        chk(n, v, s);
    endtask

    // Engine holds start until accept
    task automatic startXfer();
        @(posedge mclk) xferStart <= 1'b1;
        @(posedge mclk);
        waitOn("accept", accept, 1'b1);
        xferStart <= 1'b0;
    endtask

    // One-cycle done or cancel pulse, then one edge for the answer
    task automatic pulse(input bit cancel);
        @(posedge mclk) {xferCancel, xferDone} <= cancel ? 2'b10 : 2'b01;
        @(posedge mclk) {xferCancel, xferDone} <= 2'b00;
        @(posedge mclk);
    endtask

    task automatic tXfer();
        engMosi <= 1'b1;
        engSclk <= 1'b1;
        startXfer();
        repeat (2) @(posedge mclk);
        chk("select enables", ~roleEn, selOe_n);
        chk("active selects", actLvl & roleEn, selLines & roleEn);
        chk("sclk and mosi", 4'h5, {mosiOe_n, mosiOut, sclkOe_n, sclkOut});
        pulse(1'b0);
        repeat (2) @(posedge mclk);
        chk("idle selects", idleLvl & roleEn, selLines & roleEn);
        chk("idle sclk and mosi", 2'b00, {sclkOut, mosiOut});
        engMosi <= 1'b0;
        engSclk <= 1'b0;
        $display("tXfer finished");
    endtask

    task automatic tIrq();
        irqEn <= 1'b1;
        irqPin <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("irq seen", 1'b1, irqLevel);
        irqEn <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("irq unused", 1'b0, irqLevel);
        // Pin low again with the role on: level must follow it down
        irqPin <= 1'b0;
        irqEn <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("irq cleared", 1'b0, irqLevel);
        irqEn <= 1'b0;
        $display("tIrq finished");
    endtask

    task automatic tDrain();
        startXfer();
        wantBus <= 1'b1;
        repeat (10) @(posedge mclk);
        chk("pending", 2'b10, {pending, grantPin});
        pulse(1'b0);
        chk("released", 4'hF, {grantPin, sclkOe_n, mosiOe_n, &selOe_n});
        xferStart <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("held", 3'b100, {grantPin, busOwned, accept});
        xferStart <= 1'b0;
        wantBus <= 1'b0;
        waitOn("reclaim", busOwned, 1'b1);
        chk("grant off", 2'b00, {grantPin, sclkOe_n});
        $display("tDrain finished");
    endtask

    task automatic tCancel();
        startXfer();
        pulse(1'b1);
        chk("early cancel", 2'b00, {abort, grantPin});
        wantBus <= 1'b1;
        repeat (10) @(posedge mclk);
        pulse(1'b1);
        chk("abort", 2'b11, {abort, grantPin});
        wantBus <= 1'b0;
        waitOn("reclaim", busOwned, 1'b1);
        $display("tCancel finished");
    endtask

    task automatic tIdleReq();
        wantBus <= 1'b1;
        waitOn("idle grant", grantPin, 1'b1);
        chk("bus freed", 1'b0, busOwned);
        wantBus <= 1'b0;
        waitOn("reclaim", busOwned, 1'b1);
        arbEn <= 1'b0;
        wantBus <= 1'b1;
        startXfer();
        repeat (10) @(posedge mclk);
        chk("no grant", 1'b0, grantPin);
        pulse(1'b0);
        wantBus <= 1'b0;
        repeat (6) @(posedge mclk);
        arbEn <= 1'b1;
        $display("tIdleReq finished");
    endtask

    // Two masters never drive the clock together
    always @(posedge mclk)
        if (otherOe === 1'b1 || otherSclk === 1'b1)
            chk("clash", 1'b1, sclkOe_n);

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (16) @(posedge mclk);
        chk("reset", 2'b01, {grantPin, busOwned});
        reset_n <= 1'b1;
        @(posedge mclk);
        tXfer();
        tIrq();
        tDrain();
        tCancel();
        tIdleReq();
        report_and_stop();
    end

    // Watchdog, well beyond the expected 150 or so cycles
    initial
    begin
        repeat (4000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
endmodule
